//--- include/seq_pkg.sv
// shared constants and types for the serial command sequencer
package seq_pkg;

  // ==========================================================================
  // line buffer and characters
  localparam int BUF_LEN = 12;
  localparam logic [3:0] BUF_LAST = 4'hC;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_ESC = 8'h1B;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_SOFT = 8'h40;
  localparam logic [7:0] CH_DEL = 8'h7F;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7A;
  localparam logic [7:0] CASE_MASK = 8'hDF;

  // ==========================================================================
  // motion opcodes (upper case)
  localparam logic [7:0] OP_RUN_PROG = 8'h47;
  localparam logic [7:0] OP_WAIT = 8'h57;
  localparam logic [7:0] OP_CONST = 8'h4D;
  localparam logic [7:0] OP_HOME = 8'h46;
  localparam logic [7:0] OP_REL = 8'h52;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXEC_TYPICAL_NS = 1000000;
  localparam int EXEC_VELOCITY_NS = 4000000;
  localparam int EXEC_CLEAR_NS = 1500000000;
  localparam int EXEC_TYPICAL_CYC = EXEC_TYPICAL_NS / CLK_PERIOD_NS;
  localparam int EXEC_VELOCITY_CYC = EXEC_VELOCITY_NS / CLK_PERIOD_NS;
  localparam int EXEC_LIMIT_CYC = EXEC_CLEAR_NS / CLK_PERIOD_NS;
  localparam int WD_W = 28;
  localparam logic [2:0] SETTLE_CYC = 3'h4;

  // ==========================================================================
  // result formatting
  localparam int RES_W = 24;
  localparam int RES_DIGITS = 7;
  localparam logic [3:0] EMIT_CR = 4'h8;
  localparam logic [3:0] EMIT_LF = 4'h9;

  typedef enum logic [2:0] {
    K_PLAIN, K_RUN_PROG, K_WAIT, K_CONST, K_HOME, K_INDEX
  } cmd_kind_t;

  typedef struct packed {
    logic [BUF_LEN*8-1:0] text;
    logic [3:0] len;
    cmd_kind_t kind;
  } cmd_t;

  typedef struct packed {
    logic shared_sel_n;
    logic jog_req;
    logic go_req;
    logic soft_stop_pin;
    logic home_sensor;
  } pins_t;

  typedef struct packed {
    logic motion_busy;
    logic ramp_busy;
    logic prog_busy;
  } motor_stat_t;

endpackage

//--- src/pin_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else if (clk_en) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

//--- src/shared_line_command_sequencer.sv
// command sequencer: line entry, execution, result text and completion tracking
`timescale 1ns/1ns
// What this block does
// (R1) each reset: select pin low means shared-line mode, name loaded from storage
// (R2) shared mode: echo nothing until line feed followed by our name
// (R3) every axis listens to host line; woken axis starts echoing
// (R4) woken axis holds transmit-enable low until terminating line feed is resent
// (R5) motion commands get completion cycle; others only entry, execution, result
// (R6) idle polls jog request, go request and incoming command start
// (R7) entry buffers characters; edit only single mode; CR ends it in single mode, LF in shared mode
// (R8) escape clears buffer, leaves program mode, hard-stops, ends program
// (R9) second motion command waits for earlier completion to finish
// (R10) result is space-padded signed number then CR LF, or CR LF only; shared mode sends LF without CR
// (R11) ready output high from first character through result cycle
// (R12) completion ends per motion kind: program, motion, ramp, home, index
// (R13) non-motion commands still run while motion completes, except program
// (R14) one motion command queues during completion; execution deferred
// (R15) while queued only soft stop (byte or pin) and escape act
// (R16) pending ends with CR in single mode, LF in shared mode; running program is always pending
// (R17) soft stop acts only while commanded motion runs
// (R18) soft stop decelerates, cancels queued command, ends program
// (R19) soft stop waits for earlier ramp when queue holds speed commands
// (R20) jog and home are constant speed; home stops without ramp
// (R21) jog and command reception exclude each other
// (R22) expected execution times; longest bounds the execution watchdog
// (R23) shared mode resends terminating line feed after any result
// (R24) host keeps lines within twelve characters
// (R25) name match is exact byte compare right after line feed
module shared_line_command_sequencer import seq_pkg::*; #(
  parameter int EXEC_LIMIT = EXEC_LIMIT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire pins_t pins_raw,
  input wire motor_stat_t motor,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_ready,
  input wire logic name_ack,
  input wire logic [7:0] name_data,
  input wire logic exec_done,
  input wire logic exec_has_result,
  input wire logic signed [RES_W-1:0] exec_result,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_enable_n,
  output logic ready_n,
  output logic name_req,
  output logic exec_valid,
  output cmd_t exec_cmd,
  output logic hard_stop,
  output logic soft_stop,
  output logic prog_abort,
  output logic go_start,
  output logic jog_run,
  output logic shared_mode
);
  // ==========================================================================
  // pin synchronisation
  pins_t pins;
  pin_sync3 #(.W(5), .INIT(5'h10)) u_pin_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .din(pins_raw),
    .dout(pins)
  );

  // ==========================================================================
  // helpers
  function automatic cmd_kind_t classify(input logic [7:0] c);
    logic [7:0] u;
    u = (c >= CH_LOWER_A && c <= CH_LOWER_Z) ? (c & CASE_MASK) : c;
    if (u == OP_RUN_PROG) return K_RUN_PROG;
    if (u == OP_WAIT) return K_WAIT;
    if (u == OP_CONST) return K_CONST;
    if (u == OP_HOME) return K_HOME;
    if (u == OP_REL || u == CH_PLUS || u == CH_MINUS) return K_INDEX;
    return K_PLAIN;
  endfunction

  function automatic logic [23:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: return 24'h000001;
      3'h1: return 24'h00000A;
      3'h2: return 24'h000064;
      3'h3: return 24'h0003E8;
      3'h4: return 24'h002710;
      3'h5: return 24'h0186A0;
      default: return 24'h0F4240;
    endcase
  endfunction

  // slot k of eight: padding spaces, sign slot, then digits from the first nonzero
  function automatic logic [7:0] fmt_char(input logic [27:0] dg, input logic neg, input logic [3:0] k);
    logic [3:0] f;
    logic [3:0] d;
    f = 4'h7;
    for (int j = 7; j >= 1; j--) begin
      if (dg[(7-j)*4 +: 4] != 4'h0) f = j[3:0];
    end
    d = (k >= 4'h1) ? dg[(7 - k) * 4 +: 4] : 4'h0;
    if (k < f - 4'h1) return CH_SPACE;
    if (k == f - 4'h1) return neg ? CH_MINUS : CH_SPACE;
    return CH_ZERO + {4'h0, d};
  endfunction

  // ==========================================================================
  // state
  typedef enum logic [3:0] {
    S_LOAD, S_IDLE, S_JOG, S_ENTRY, S_PENDING, S_EXEC, S_DIGITS, S_EMIT, S_DRAIN
  } state_t;

  state_t state_q, state_d;
  logic [2:0] settle_q, settle_d;
  logic [7:0] name_q, name_d;
  logic shared_q, shared_d, awake_q, awake_d, last_lf_q, last_lf_d;
  logic [BUF_LEN*8-1:0] buf_q, buf_d;
  logic [3:0] len_q, len_d;
  cmd_kind_t kind_q, kind_d, compl_kind_q, compl_kind_d;
  logic compl_q, compl_d, sent_q, sent_d, soft_hold_q, soft_hold_d;
  logic go_prev_q, go_prev_d, soft_prev_q, soft_prev_d;
  logic [WD_W-1:0] wd_q, wd_d;
  logic [23:0] mag_q, mag_d;
  logic [2:0] didx_q, didx_d;
  logic [27:0] dig_q, dig_d;
  logic neg_q, neg_d, has_res_q, has_res_d;
  logic [3:0] emit_q, emit_d;
  logic tx_valid_q, tx_valid_d, txen_n_q, txen_n_d, ready_n_q, ready_n_d, name_req_q, name_req_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic exec_valid_q, exec_valid_d, hard_q, hard_d, soft_q, soft_d, pabort_q, pabort_d;
  logic go_q, go_d, jog_q, jog_d;
  logic compl_end, echo_ok, esc_in, soft_in, soft_req, soft_fire;
  logic [7:0] term;

  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    name_d = name_q;
    shared_d = shared_q;
    awake_d = awake_q;
    last_lf_d = rx_valid ? (rx_byte == CH_LF) : last_lf_q;
    buf_d = buf_q;
    len_d = len_q;
    kind_d = kind_q;
    compl_d = compl_q;
    compl_kind_d = compl_kind_q;
    sent_d = sent_q;
    soft_hold_d = soft_hold_q;
    go_prev_d = pins.go_req;
    soft_prev_d = pins.soft_stop_pin;
    wd_d = wd_q;
    mag_d = mag_q;
    didx_d = didx_q;
    dig_d = dig_q;
    neg_d = neg_q;
    has_res_d = has_res_q;
    emit_d = emit_q;
    tx_valid_d = (tx_valid_q && tx_ready) ? 1'b0 : tx_valid_q;
    tx_byte_d = tx_byte_q;
    txen_n_d = txen_n_q;
    ready_n_d = ready_n_q;
    name_req_d = name_req_q;
    exec_valid_d = 1'b0;
    hard_d = 1'b0;
    soft_d = 1'b0;
    pabort_d = 1'b0;
    go_d = 1'b0;
    jog_d = jog_q;
    term = shared_q ? CH_LF : CH_CR; // R7
    echo_ok = !shared_q || awake_q; // R2 R3
    esc_in = rx_valid && rx_byte == CH_ESC;
    soft_in = rx_valid && rx_byte == CH_SOFT;
    // completion end per motion kind
    unique case (compl_kind_q) // R12
      K_RUN_PROG: compl_end = !motor.prog_busy;
      K_WAIT: compl_end = !motor.motion_busy;
      K_CONST: compl_end = !motor.ramp_busy;
      K_HOME: compl_end = pins.home_sensor; // R20
      K_INDEX: compl_end = !motor.motion_busy;
      default: compl_end = 1'b1;
    endcase
    if (compl_q && compl_end) compl_d = 1'b0;

    unique case (state_q)
      S_LOAD: begin
        // let the select pin settle through the synchroniser before sampling it
        if (settle_q != SETTLE_CYC) begin
          settle_d = settle_q + 3'h1;
        end else if (name_ack && name_req_q) begin
          name_req_d = 1'b0;
          name_d = name_data; // R1
          shared_d = !pins.shared_sel_n; // R1
          ready_n_d = 1'b0;
          state_d = S_IDLE;
        end else begin
          name_req_d = 1'b1;
        end
      end
      S_IDLE: begin // R6
        if (rx_valid && !esc_in && !soft_in) begin
          if (compl_q && compl_kind_q == K_RUN_PROG) begin
            // running program counts as pending: other input ignored
          end else if (shared_q) begin
            if (last_lf_q && rx_byte == name_q) begin // R25 R2
              awake_d = 1'b1;
              txen_n_d = 1'b0; // R4
              tx_valid_d = 1'b1; // R3
              tx_byte_d = rx_byte;
              len_d = 4'h0;
              ready_n_d = 1'b1; // R11
              state_d = S_ENTRY;
            end
          end else if (rx_byte != CH_CR && rx_byte != CH_LF) begin
            buf_d[7:0] = rx_byte;
            len_d = 4'h1;
            tx_valid_d = 1'b1;
            tx_byte_d = rx_byte;
            ready_n_d = 1'b1; // R11 R21
            state_d = S_ENTRY;
          end
        end else if (!rx_valid && !compl_q) begin
          if (pins.jog_req) begin // R21
            jog_d = 1'b1;
            state_d = S_JOG;
          end else if (pins.go_req && !go_prev_q) begin
            go_d = 1'b1;
            compl_d = 1'b1;
            compl_kind_d = K_RUN_PROG;
          end
        end
      end
      S_JOG: begin
        // characters other than escape arriving while jogging are dropped
        if (!pins.jog_req) jog_d = 1'b0; // R21
        if (!jog_q && !motor.motion_busy) state_d = S_IDLE;
      end
      S_ENTRY: begin
        if (rx_valid && !esc_in) begin
          if (rx_byte == term) begin
            kind_d = classify(buf_q[7:0]);
            sent_d = 1'b0;
            wd_d = '0;
            if (compl_q && (kind_d != K_PLAIN || compl_kind_q == K_RUN_PROG)) begin
              state_d = S_PENDING; // R9 R13 R14
            end else begin
              state_d = S_EXEC;
            end
          end else if (!shared_q && (rx_byte == CH_BS || rx_byte == CH_DEL)) begin
            if (len_q != 4'h0) len_d = len_q - 4'h1; // R7
            tx_valid_d = 1'b1;
            tx_byte_d = rx_byte;
          end else begin
            if (len_q != BUF_LAST) begin // R24
              buf_d[{len_q, 3'b000} +: 8] = rx_byte;
              len_d = len_q + 4'h1;
            end
            tx_valid_d = echo_ok;
            tx_byte_d = rx_byte;
          end
        end
      end
      S_PENDING: begin // R15 R16
        if (!compl_q || compl_end) state_d = S_EXEC;
      end
      S_EXEC: begin // R5
        exec_valid_d = !sent_q;
        sent_d = 1'b1;
        wd_d = wd_q + 1'b1;
        if (sent_q && (exec_done || wd_q >= EXEC_LIMIT[WD_W-1:0])) begin // R22
          if (kind_q != K_PLAIN) begin // R5
            compl_d = 1'b1;
            compl_kind_d = kind_q;
          end
          has_res_d = exec_done && exec_has_result;
          neg_d = exec_result[RES_W-1];
          mag_d = exec_result[RES_W-1] ? 24'(-exec_result) : 24'(exec_result);
          dig_d = '0;
          didx_d = 3'(RES_DIGITS - 1);
          emit_d = has_res_d ? 4'h0 : EMIT_CR;
          if (has_res_d) state_d = S_DIGITS;
          else state_d = S_EMIT;
        end
      end
      S_DIGITS: begin
        // one subtraction per cycle keeps the result path free of dividers
        if (mag_q >= pow10(didx_q)) begin
          mag_d = mag_q - pow10(didx_q);
          dig_d[{didx_q, 2'b00} +: 4] = dig_q[{didx_q, 2'b00} +: 4] + 4'h1;
        end else if (didx_q == 3'h0) begin
          state_d = S_EMIT;
        end else begin
          didx_d = didx_q - 3'h1;
        end
      end
      S_EMIT: begin // R10 R23
        if (!tx_valid_q || tx_ready) begin
          tx_valid_d = 1'b1;
          if (emit_q == EMIT_LF) begin
            tx_byte_d = CH_LF;
            state_d = S_DRAIN;
          end else if (emit_q == EMIT_CR) begin
            tx_byte_d = CH_CR;
            tx_valid_d = !shared_q;
            emit_d = EMIT_LF;
          end else begin
            tx_byte_d = fmt_char(dig_q, neg_q, emit_q);
            emit_d = emit_q + 4'h1;
          end
        end
      end
      S_DRAIN: begin
        if (!tx_valid_q || tx_ready) begin
          txen_n_d = 1'b1; // R4
          awake_d = 1'b0;
          ready_n_d = 1'b0; // R11
          len_d = 4'h0;
          state_d = S_IDLE;
        end
      end
      default: state_d = S_LOAD;
    endcase

    // soft stop: only while commanded motion runs
    soft_req = motor.motion_busy && state_q != S_LOAD && state_q != S_JOG
      && ((soft_in && (state_q == S_IDLE || state_q == S_PENDING))
      || (pins.soft_stop_pin && !soft_prev_q)); // R17
    if (soft_req && state_q == S_PENDING && kind_q == K_CONST && compl_kind_q == K_CONST
        && motor.ramp_busy) begin
      soft_hold_d = 1'b1; // R19
    end
    soft_fire = (soft_req && !soft_hold_d) || (soft_hold_q && !motor.ramp_busy);
    if (soft_fire) begin // R18
      soft_hold_d = 1'b0;
      soft_d = 1'b1;
      if (compl_q && compl_kind_q == K_RUN_PROG) pabort_d = 1'b1;
      if (state_q == S_PENDING) begin
        state_d = S_IDLE;
        len_d = 4'h0;
        ready_n_d = 1'b0;
        awake_d = 1'b0;
        txen_n_d = 1'b1;
      end
    end

    // escape aborts everything at once, addressed or not
    if (esc_in && state_q != S_LOAD) begin // R8
      hard_d = 1'b1;
      pabort_d = 1'b1;
      soft_hold_d = 1'b0;
      compl_d = 1'b0;
      len_d = 4'h0;
      jog_d = 1'b0;
      awake_d = 1'b0;
      txen_n_d = 1'b1;
      ready_n_d = 1'b0;
      state_d = S_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= S_LOAD;
      settle_q <= 3'h0;
      name_q <= 8'h00;
      shared_q <= 1'b0;
      awake_q <= 1'b0;
      last_lf_q <= 1'b0;
      buf_q <= '0;
      len_q <= 4'h0;
      kind_q <= K_PLAIN;
      compl_q <= 1'b0;
      compl_kind_q <= K_PLAIN;
      sent_q <= 1'b0;
      soft_hold_q <= 1'b0;
      go_prev_q <= 1'b0;
      soft_prev_q <= 1'b0;
      wd_q <= '0;
      mag_q <= 24'h000000;
      didx_q <= 3'h0;
      dig_q <= 28'h0000000;
      neg_q <= 1'b0;
      has_res_q <= 1'b0;
      emit_q <= 4'h0;
      tx_valid_q <= 1'b0;
      tx_byte_q <= 8'h00;
      txen_n_q <= 1'b1;
      ready_n_q <= 1'b1;
      name_req_q <= 1'b0;
      exec_valid_q <= 1'b0;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
      pabort_q <= 1'b0;
      go_q <= 1'b0;
      jog_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      settle_q <= settle_d;
      name_q <= name_d;
      shared_q <= shared_d;
      awake_q <= awake_d;
      last_lf_q <= last_lf_d;
      buf_q <= buf_d;
      len_q <= len_d;
      kind_q <= kind_d;
      compl_q <= compl_d;
      compl_kind_q <= compl_kind_d;
      sent_q <= sent_d;
      soft_hold_q <= soft_hold_d;
      go_prev_q <= go_prev_d;
      soft_prev_q <= soft_prev_d;
      wd_q <= wd_d;
      mag_q <= mag_d;
      didx_q <= didx_d;
      dig_q <= dig_d;
      neg_q <= neg_d;
      has_res_q <= has_res_d;
      emit_q <= emit_d;
      tx_valid_q <= tx_valid_d;
      tx_byte_q <= tx_byte_d;
      txen_n_q <= txen_n_d;
      ready_n_q <= ready_n_d;
      name_req_q <= name_req_d;
      exec_valid_q <= exec_valid_d;
      hard_q <= hard_d;
      soft_q <= soft_d;
      pabort_q <= pabort_d;
      go_q <= go_d;
      jog_q <= jog_d;
    end
  end

  // ==========================================================================
  // outputs
  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
  assign tx_enable_n = txen_n_q;
  assign ready_n = ready_n_q;
  assign name_req = name_req_q;
  assign exec_valid = exec_valid_q;
  assign exec_cmd = '{text: buf_q, len: len_q, kind: kind_q};
  assign hard_stop = hard_q;
  assign soft_stop = soft_q;
  assign prog_abort = pabort_q;
  assign go_start = go_q;
  assign jog_run = jog_q;
  assign shared_mode = shared_q;
endmodule

//--- sim/seq_props.sv
// concurrent checks on the ports of the serial command sequencer
`timescale 1ns/1ns
module seq_props import seq_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire motor_stat_t motor,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_ready,
  input wire logic name_ack,
  input wire logic [7:0] name_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_enable_n,
  input wire logic ready_n,
  input wire logic name_req,
  input wire logic exec_valid,
  input wire logic hard_stop,
  input wire logic soft_stop,
  input wire logic prog_abort,
  input wire logic jog_run,
  input wire logic shared_mode
);
  logic loaded_q, lf_q, rx_go;
  logic [7:0] name_q;
  assign rx_go = rx_valid && clk_en;
  // ==========================================================================
  // helper state: loaded name and whether the last byte was a line feed
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loaded_q <= 1'b0;
      lf_q <= 1'b0;
      name_q <= 8'h00;
    end else if (clk_en) begin
      if (name_req && name_ack) begin
        loaded_q <= 1'b1;
        name_q <= name_data;
      end
      if (rx_valid) begin
        lf_q <= rx_byte == CH_LF;
      end
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |-> !tx_valid && tx_enable_n && ready_n && !name_req)
    else $error("outputs not idle after reset");
  a_name_wait: assert property (name_req && !name_ack |=> name_req)
    else $error("name request dropped early");
  a_load_ready: assert property (name_req && name_ack && clk_en |=> !ready_n && !name_req)
    else $error("not ready after name load");
  a_shared_silent: assert property (shared_mode && tx_enable_n |-> !tx_valid)
    else $error("sleeping axis transmits");
  a_wake_name: assert property (loaded_q && shared_mode && tx_enable_n && !ready_n && lf_q && rx_go
    && rx_byte == name_q |=> !tx_enable_n && tx_valid && tx_byte == name_q)
    else $error("axis did not wake on its name");
  a_no_wake: assert property (loaded_q && shared_mode && tx_enable_n && rx_go
    && !(lf_q && rx_byte == name_q) |=> tx_enable_n)
    else $error("axis woke without its name");
  a_single_enable: assert property (loaded_q && !shared_mode |-> tx_enable_n)
    else $error("transmit enable low in single mode");
  a_esc_abort: assert property (loaded_q && rx_go && rx_byte == CH_ESC
    |=> hard_stop && prog_abort && !ready_n && tx_enable_n)
    else $error("escape did not abort");
  a_ready_busy: assert property (loaded_q && !shared_mode && !ready_n && !jog_run && rx_go
    && rx_byte != CH_ESC && rx_byte != CH_SOFT |=> ready_n)
    else $error("ready stays low on command start");
  a_exec_ready: assert property (exec_valid |-> ready_n)
    else $error("execution while ready low");
  a_jog_excl: assert property (jog_run |-> !exec_valid)
    else $error("execution while jogging");
  a_soft_busy: assert property (soft_stop |-> $past(motor.motion_busy))
    else $error("soft stop without motion");
  a_tx_hold: assert property (tx_valid && !tx_ready && !rx_go |=> tx_valid && $stable(tx_byte))
    else $error("transmit byte not held");
  c_wake: cover property (!tx_enable_n && tx_valid);
  c_soft: cover property (soft_stop);
  c_jog: cover property (jog_run);
endmodule
bind shared_line_command_sequencer seq_props u_props (.*);

//--- sim/host_model.sv
// host end of the serial link: takes transmitted bytes, sometimes stalling
`timescale 1ns/1ns
module host_model (
  input wire logic clk_sys,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic slow,
  output logic tx_ready
);
  logic [7:0] got[$];
  int hseed = 32'h5d54;
  // a slow host stalls two cycles in three to stress the held byte
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
    tx_ready <= !slow || ({$random(hseed)} % 3 == 0);
  end
endmodule

//--- sim/testbench.sv
// self-checking bench for the serial command sequencer
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module testbench import seq_pkg::*;;
  localparam logic [7:0] NAME = 8'h4B;
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, rx_valid = 1'b0, name_ack = 1'b0;
  logic exec_done = 1'b0, exec_has_result = 1'b0, slow = 1'b0, res_has = 1'b0;
  logic [7:0] rx_byte = 8'h00, name_data = 8'h00, tx_byte;
  logic signed [RES_W-1:0] exec_result = '0, res_val = '0;
  pins_t pins_raw = '{shared_sel_n: 1'b1, default: 1'b0};
  motor_stat_t motor = '0;
  logic tx_ready, tx_valid, tx_enable_n, ready_n, name_req, exec_valid;
  logic hard_stop, soft_stop, prog_abort, go_start, jog_run, shared_mode;
  cmd_t exec_cmd, last_cmd;
  int errors = 0, n_compared = 0, seed = 32'h5d54, cyc = 0, n_exec = 0, n_soft = 0, n_go = 0, n0, i;
  string ops = "GWMFR+-Q";
  always #5 clk_sys = ~clk_sys;
  shared_line_command_sequencer #(.EXEC_LIMIT(200)) u_dut (.*);
  host_model u_host (.*);
  // ==========================================================================
  // executor stand-in and monitors
  always @(posedge clk_sys) begin
    exec_done <= 1'b0;
    if (exec_valid === 1'b1) begin
      n_exec++;
      last_cmd = exec_cmd;
      repeat (1 + {$random(seed)} % 4) @(posedge clk_sys);
      exec_done <= 1'b1;
      exec_has_result <= res_has;
      exec_result <= res_val;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (soft_stop === 1'b1) n_soft++;
    if (go_start === 1'b1) n_go++;
    if (cyc == 60000) begin
      errors++;
      print_verdict();
    end
  end
  // ==========================================================================
  // helpers
  function automatic cmd_kind_t kind_of(logic [7:0] c);
    logic [7:0] u;
    u = (c >= CH_LOWER_A && c <= CH_LOWER_Z) ? c & CASE_MASK : c;
    case (u)
      OP_RUN_PROG: return K_RUN_PROG;
      OP_WAIT: return K_WAIT;
      OP_CONST: return K_CONST;
      OP_HOME: return K_HOME;
      OP_REL, CH_PLUS, CH_MINUS: return K_INDEX;
      default: return K_PLAIN;
    endcase
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // md 0: expect no echo, 1: expect echo, 2: no wait
  task automatic send(logic [7:0] b, int md);
    int n;
    n = u_host.got.size();
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    if (md == 2) return;
    repeat (60) begin
      @(posedge clk_sys);
      if (u_host.got.size() > n) break;
    end
    if (md == 1) `CHK("echo", u_host.got[$], b)
    else `CHK("silent", u_host.got.size(), n)
  endtask
  task automatic line(string s, bit sh);
    string e;
    int k;
    if (sh) begin
      send(CH_LF, 0);
      send(NAME, 1);
      `CHK("wake", tx_enable_n, 1'b0)
    end
    for (k = 0; k < s.len(); k++) begin
      send(s[k], 1);
      `CHK("ready", ready_n, 1'b1)
    end
    e = {res_has ? $sformatf("%8d", res_val) : "", sh ? "" : "\r", "\n"};
    send(sh ? CH_LF : CH_CR, 2);
    repeat (900) begin
      @(posedge clk_sys);
      if (ready_n === 1'b0) break;
    end
    for (k = 0; k < e.len(); k++) `CHK("result", u_host.got[u_host.got.size() - e.len() + k], e[k])
    `CHK("kind", last_cmd.kind, kind_of(s[0]))
    `CHK("len", last_cmd.len, s.len() > BUF_LEN ? BUF_LAST : 4'(s.len()))
    `CHK("txen", tx_enable_n, 1'b1)
  endtask
  task automatic load(bit sh);
    repeat (30) begin
      @(posedge clk_sys);
      if (name_req === 1'b1) break;
    end
    name_data <= NAME;
    name_ack <= 1'b1;
    @(posedge clk_sys);
    name_ack <= 1'b0;
    tick(3);
    `CHK("loaded", ready_n, 1'b0)
    `CHK("mode", shared_mode, sh)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    tick(8);
    reset <= 1'b0;
    load(1'b0);
    pins_raw.home_sensor <= 1'b1;
    for (i = 0; i < 6; i++) begin
      res_has = i != 5;
      res_val = i == 0 ? '0 : i == 1 ? -24'sd1 : $random(seed) % 8000000;
      slow <= i[0];
      line("z 12", 1'b0);
    end
    slow <= 1'b0;
    res_has = 1'b0;
    $display("done: result lines");
    for (i = 0; i < ops.len(); i++) line(ops.substr(i, i), 1'b0);
    line("R12345678901", 1'b0);
    $display("done: opcodes");
    motor.motion_busy <= 1'b1;
    line("+5", 1'b0);
    line("Z", 1'b0);
    n0 = n_exec;
    fork
      begin
        tick(150);
        `CHK("held", n_exec, n0)
        motor.motion_busy <= 1'b0;
      end
    join_none
    line("-3", 1'b0);
    `CHK("queued", n_exec, n0 + 1)
    $display("done: pending");
    for (i = 0; i < 2; i++) begin
      motor.motion_busy <= i[0];
      tick(2);
      n0 = n_soft;
      send(CH_SOFT, 2);
      tick(10);
      `CHK("soft", n_soft, n0 + i)
    end
    motor.motion_busy <= 1'b0;
    n0 = n_exec;
    send("Z", 1);
    send(CH_ESC, 2);
    tick(4);
    `CHK("abort", ready_n, 1'b0)
    `CHK("abort", n_exec, n0)
    line("Z", 1'b0);
    $display("done: stops");
    clk_en <= 1'b0;
    pins_raw.go_req <= 1'b1;
    tick(12);
    `CHK("frz", n_go, 0)
    clk_en <= 1'b1;
    tick(12);
    pins_raw.go_req <= 1'b0;
    `CHK("go", n_go, 1)
    pins_raw.jog_req <= 1'b1;
    tick(12);
    `CHK("jog", jog_run, 1'b1)
    n0 = n_exec;
    send("Z", 0);
    pins_raw.jog_req <= 1'b0;
    tick(12);
    `CHK("jog", jog_run, 1'b0)
    `CHK("jog", n_exec, n0)
    $display("done: go and jog");
    pins_raw.shared_sel_n <= 1'b0;
    reset <= 1'b1;
    tick(8);
    reset <= 1'b0;
    load(1'b1);
    send("Q", 0);
    send(CH_LF, 0);
    send(NAME ^ 8'h20, 0);
    line("+7", 1'b1);
    res_has = 1'b1;
    res_val = -24'sd4711;
    line("Z", 1'b1);
    $display("done: shared line");
    print_verdict();
  end
endmodule
